// ### design/ssc_stat_counters.sv
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "ssc_map.svh"

// Contract
// - 32 counters each for three ports
// - Bit 31 flags counter overflow, resets zero
// - Bit 30 valid, bits 29:0 count
// - Ports at 0x00, 0x20, 0x40 indirect
// - Control register bit 12 selects read
// - Control bits 9:0 hold indirect address
// - Data returned in low/high data registers
// - Offset 0 receive octets; 1 reserved
// - Short good and short bad receive counts
// - Long good and long bad receive counts
// - Offset 6 counts bad symbol packets
// - Checksum fail, whole and odd length
// - MAC control and pause frames received
// - Good broadcast, multicast, unicast received
// - Six receive length bins, 0xE-0x13
// - Offset 0x14 transmit octets; 0x15 reserved
// - Late transmit collisions at 0x16
// - Pause and good cast transmit counts
// - Deferred first transmit attempts at 0x1B
// - Collision counts at 0x1C to 0x1F
// - Drop counters are plain 16 bits
// - Drop counters at 0x100,0x101,0x103,0x104
// - Control write starts read, data presented
// - High word bits 31:16, low 15:0
// - Reading a port counter clears it
// - Reading a drop counter keeps it
module ssc_stat_counters
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic [31:0] event_port1,
  input  wire logic [31:0] event_port2,
  input  wire logic [31:0] event_host,
  input  wire logic [10:0] rx_octets_port1,
  input  wire logic [10:0] rx_octets_port2,
  input  wire logic [10:0] rx_octets_host,
  input  wire logic [10:0] tx_octets_port1,
  input  wire logic [10:0] tx_octets_port2,
  input  wire logic [10:0] tx_octets_host,
  input  wire logic [3:0]  drop_event
);

  // Every check below runs on the bus clock and rests during reset
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ************************************************************
  // Address classification
  // ************************************************************

  // Which kind of counter an indirect address names
  function automatic ssc_pkg::ssc_kind_e ssc_kind(input logic [9:0] a);
    logic [4:0] ofs;
    ofs = a[4:0];
    if (a < `SSC_PORT_LIMIT && ofs != `SSC_RSVD_RX && ofs != `SSC_RSVD_TX)
      ssc_kind = ssc_pkg::SSC_KIND_PORT;
    else if (a == `SSC_DROP_TX_P1 || a == `SSC_DROP_TX_P2 || a == `SSC_DROP_RX_P1 || a == `SSC_DROP_RX_P2)
      ssc_kind = ssc_pkg::SSC_KIND_DROP;
    else
      ssc_kind = ssc_pkg::SSC_KIND_NONE;
  endfunction : ssc_kind

  // Drop counter slot: tx p1, tx p2, rx p1, rx p2
  function automatic logic [1:0] ssc_drop_slot(input logic [9:0] a);
    if (a == `SSC_DROP_TX_P1)
      ssc_drop_slot = 2'h0;
    else if (a == `SSC_DROP_TX_P2)
      ssc_drop_slot = 2'h1;
    else if (a == `SSC_DROP_RX_P1)
      ssc_drop_slot = 2'h2;
    else
      ssc_drop_slot = 2'h3;
  endfunction : ssc_drop_slot

  // Register word seen by a read; unmapped words and upper lanes give zero
  function automatic logic [31:0] ssc_read_word(input logic [13:0] a, input logic [15:0] c, input logic [31:0] s);
    if (a == `SSC_ADDR_CTRL)
      ssc_read_word = {16'h0000, c};
    else if (a == `SSC_ADDR_DATA_LO)
      ssc_read_word = {16'h0000, s[15:0]};
    else if (a == `SSC_ADDR_DATA_HI)
      ssc_read_word = {16'h0000, s[31:16]};
    else
      ssc_read_word = 32'h0000_0000;
  endfunction : ssc_read_word

  // ************************************************************
  // Bus slave
  // ************************************************************

  logic        dp_valid;
  logic        dp_write;
  logic [13:0] dp_addr;
  logic [15:0] ctrl;
  logic [31:0] snap;
  logic        ctrl_wr;
  logic        cmd_read;
  logic [9:0]  cmd_addr;
  logic [15:0] next_ctrl;
  logic [31:0] next_snap;

  // Every access completes with no wait state and an OKAY answer
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Capture the address phase; only the low 14 address bits decode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 14'h0000;
    end
    else if (hready)
    begin
      dp_valid <= hsel && htrans[1];
      dp_write <= hwrite;
      dp_addr  <= haddr[13:0];
    end
  end

  assign ctrl_wr  = dp_valid && dp_write && dp_addr == `SSC_ADDR_CTRL;
  // A statistics read is requested by bit 12 plus the table select
  assign cmd_read = ctrl_wr && hwdata[`SSC_CTRL_READ_BIT]
                    && hwdata[`SSC_CTRL_SEL_HI:`SSC_CTRL_SEL_LO] == `SSC_SEL_STATS;
  assign cmd_addr = hwdata[`SSC_CTRL_ADDR_HI:0];

  // Control register holds the last command written
  assign next_ctrl = ctrl_wr ? hwdata[15:0] : ctrl;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl <= `SSC_CTRL_RESET;
    else
      ctrl <= next_ctrl;
  end

  // Read data is a flop loaded at the address phase; it looks at the
  // next control and snapshot values, so a read issued on the command's
  // data-phase edge already returns the fresh capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hready)
    begin
      if (hsel && htrans[1] && !hwrite)
        hrdata <= ssc_read_word(haddr[13:0], next_ctrl, next_snap);
      else
        hrdata <= 32'h0000_0000;
    end
  end

  // ************************************************************
  // Per-port counters
  // ************************************************************

  logic [95:0]         all_ev;
  logic [10:0]         rx_oct [`SSC_PORTS];
  logic [10:0]         tx_oct [`SSC_PORTS];
  ssc_pkg::ssc_count_t cnt    [`SSC_NUM_COUNTERS];
  logic [95:0]         ovf;
  logic                cap_port;
  logic [6:0]          cap_idx;

  assign all_ev    = {event_host, event_port2, event_port1};
  assign rx_oct[0] = rx_octets_port1;
  assign rx_oct[1] = rx_octets_port2;
  assign rx_oct[2] = rx_octets_host;
  assign tx_oct[0] = tx_octets_port1;
  assign tx_oct[1] = tx_octets_port2;
  assign tx_oct[2] = tx_octets_host;
  assign cap_port  = cmd_read && ssc_kind(cmd_addr) == ssc_pkg::SSC_KIND_PORT;
  assign cap_idx   = cmd_addr[6:0];

  for (genvar i = 0; i < `SSC_NUM_COUNTERS; i++)
  begin : g_cnt
    localparam logic [4:0] OFS  = 5'(i % `SSC_PER_PORT);
    localparam int         PORT = i / `SSC_PER_PORT;
    logic [29:0] amount;
    logic [30:0] sum;
    logic        inc;
    logic        clr;

    // Octet counters add a length; every other counter steps by one
    assign amount = (OFS == `SSC_OFS_RX_OCTETS) ? {19'h00000, rx_oct[PORT]} :
                    (OFS == `SSC_OFS_TX_OCTETS) ? {19'h00000, tx_oct[PORT]} : 30'h0000_0001;
    // Reserved slots never count so their reads stay zero
    assign inc = all_ev[i] && OFS != `SSC_RSVD_RX && OFS != `SSC_RSVD_TX;
    assign clr = cap_port && cap_idx == 7'(i);
    assign sum = {1'b0, cnt[i]} + {1'b0, amount};

    // Read clears; an event in the clearing cycle is kept, not lost
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        cnt[i] <= 30'h0000_0000;
        ovf[i] <= 1'b0;
      end
      else if (clr)
      begin
        cnt[i] <= inc ? amount : 30'h0000_0000;
        ovf[i] <= 1'b0;
      end
      else if (inc)
      begin
        cnt[i] <= sum[29:0];
        if (sum[30])
          ovf[i] <= 1'b1;
      end
    end

    // Wrap of the count raises the sticky overflow flag
    a_ovf_on_wrap: assert property (inc && !clr && sum[30] |=> ovf[i])
      else $error("overflow flag not set on counter wrap");

    // A single event on a plain counter advances it by one
    a_count_step: assert property (inc && !clr && amount == 30'h0000_0001 && !sum[30]
                                   |=> cnt[i] == $past(cnt[i]) + 30'h0000_0001)
      else $error("counter did not advance by one");
  end

  // ************************************************************
  // Dropped-packet counters
  // ************************************************************

  ssc_pkg::ssc_drop_t drop [4];
  logic               cap_drop;
  logic [1:0]         cap_slot;

  assign cap_drop = cmd_read && ssc_kind(cmd_addr) == ssc_pkg::SSC_KIND_DROP;
  assign cap_slot = ssc_drop_slot(cmd_addr);

  // Plain wrapping 16-bit counts, untouched by reads
  for (genvar d = 0; d < 4; d++)
  begin : g_drop
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        drop[d] <= 16'h0000;
      else if (drop_event[d])
        drop[d] <= drop[d] + 16'h0001;
    end
  end

  // ************************************************************
  // Snapshot of the addressed counter
  // ************************************************************

  // Taken on the control write itself, so the next data read sees it
  always_comb
  begin
    next_snap = snap;
    if (cap_port)
      next_snap = {ovf[cap_idx], 1'b1, cnt[cap_idx]};
    else if (cap_drop)
      next_snap = {16'h0000, drop[cap_slot]};
    else if (cmd_read)
      next_snap = 32'h0000_0000;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      snap <= 32'h0000_0000;
    else
      snap <= next_snap;
  end

  // ************************************************************
  // Checks
  // ************************************************************

  sequence s_port_cmd;
    cap_port && !all_ev[cap_idx];
  endsequence

  sequence s_drop_cmd;
    cap_drop && !drop_event[cap_slot];
  endsequence

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave did not answer ready and okay");

  a_snap_count: assert property (cap_port |=> snap[30] && snap[29:0] == $past(cnt[cap_idx])
                                 && snap[31] == $past(ovf[cap_idx]))
    else $error("snapshot does not match addressed counter");

  a_clear_on_read: assert property (s_port_cmd |=> cnt[$past(cap_idx)] == 30'h0000_0000
                                    && !ovf[$past(cap_idx)])
    else $error("port counter not cleared by read");

  a_drop_kept: assert property (s_drop_cmd |=> drop[$past(cap_slot)] == $past(drop[cap_slot]))
    else $error("drop counter changed by read");

  a_drop_format: assert property (cap_drop |=> snap[31:16] == 16'h0000)
    else $error("drop snapshot carries upper bits");

  a_reserved_zero: assert property (cmd_read && ssc_kind(cmd_addr) == ssc_pkg::SSC_KIND_NONE
                                    |=> snap == 32'h0000_0000)
    else $error("reserved counter read not zero");

  a_high_word: assert property (dp_valid && !dp_write && dp_addr == `SSC_ADDR_DATA_HI
                                |-> hrdata == {16'h0000, snap[31:16]})
    else $error("high data word mismatch");

  a_low_word: assert property (dp_valid && !dp_write && dp_addr == `SSC_ADDR_DATA_LO
                               |-> hrdata == {16'h0000, snap[15:0]})
    else $error("low data word mismatch");

  a_ctrl_read: assert property (dp_valid && !dp_write && dp_addr == `SSC_ADDR_CTRL
                                |-> hrdata == {16'h0000, ctrl})
    else $error("control register read mismatch");

  // Outside a read data phase the bus sees zero, never stale data
  a_read_idle: assert property (!(dp_valid && !dp_write) |-> hrdata == 32'h0000_0000)
    else $error("read data not zero outside read phase");

  a_ctrl_hold: assert property (ctrl_wr ##1 !ctrl_wr [*2] |-> ctrl == $past(hwdata[15:0], 2))
    else $error("control register lost its value");

  // Unused bus inputs: every access is taken as a whole word
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize};

endmodule : ssc_stat_counters

// ### design/ssc_map.svh
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH
// Register indices and word-aligned byte addresses (byte address = 4 * index)
`define SSC_IDX_CTRL        12'h4a0
`define SSC_IDX_DATA_LO     12'h4a8
`define SSC_IDX_DATA_HI     12'h4aa
`define SSC_ADDR_CTRL       14'h1280
`define SSC_ADDR_DATA_LO    14'h12a0
`define SSC_ADDR_DATA_HI    14'h12a8
// Control register fields
`define SSC_CTRL_RESET      16'h0000
`define SSC_CTRL_READ_BIT   12
`define SSC_CTRL_SEL_HI     11
`define SSC_CTRL_SEL_LO     10
`define SSC_CTRL_ADDR_HI    9
`define SSC_SEL_STATS       2'h3
// Counter word fields
`define SSC_OVF_BIT         31
`define SSC_VALID_BIT       30
`define SSC_COUNT_W         30
`define SSC_DROP_W          16
// Indirect counter space
`define SSC_PORTS           3
`define SSC_PER_PORT        32
`define SSC_NUM_COUNTERS    96
`define SSC_PORT_LIMIT      10'h060
`define SSC_RSVD_RX         5'h01
`define SSC_RSVD_TX         5'h15
`define SSC_OFS_RX_OCTETS   5'h00
`define SSC_OFS_TX_OCTETS   5'h14
`define SSC_DROP_TX_P1      10'h100
`define SSC_DROP_TX_P2      10'h101
`define SSC_DROP_RX_P1      10'h103
`define SSC_DROP_RX_P2      10'h104
`define SSC_OCTET_W         11
`endif

// ### design/ssc_pkg.sv
package ssc_pkg;
  typedef logic [29:0] ssc_count_t;
  typedef logic [15:0] ssc_drop_t;
  // Class of an indirect address
  typedef enum logic [2:0]
  {
    SSC_KIND_PORT = 3'b001,
    SSC_KIND_DROP = 3'b010,
    SSC_KIND_NONE = 3'b100
  } ssc_kind_e;
endpackage : ssc_pkg

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "ssc_map.svh"

module tb_top;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [31:0] ev [3];
  logic [10:0] rxo [3];
  logic [10:0] txo [3];
  logic [3:0]  drop_event;
  logic [29:0] cnt [96];
  logic [15:0] drp [4];
  logic [15:0] expq [$];
  logic        rd_dp;
  int          bad_count;
  int          comparisons;
  integer      seed;

  ssc_stat_counters u_ssc_stat_counters
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .event_port1(ev[0]), .event_port2(ev[1]), .event_host(ev[2]),
    .rx_octets_port1(rxo[0]), .rx_octets_port2(rxo[1]), .rx_octets_host(rxo[2]),
    .tx_octets_port1(txo[0]), .tx_octets_port2(txo[1]), .tx_octets_host(txo[2]),
    .drop_event(drop_event)
  );

  // ****************************************
  // Clock, checking and bus tasks
  // ****************************************
  // Free running 100 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task report_and_stop;
    if (expq.size() != 0) bad_count++;
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Watch read data phases; the oldest noted value belongs to this one
  always @(posedge hclk)
  begin
    if (rd_dp)
    begin
      chk(hrdata, (expq.size() > 0) ? {16'h0, expq.pop_front()} : 32'hdead_beef);
      chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
    end
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout && hresetn;
  end

  // Bounded wait for hready; a hang ends the run as a failure
  task wait_rdy;
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 20);
    if (hreadyout !== 1'b1)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask : wait_rdy

  task xfer(input logic w, input logic [13:0] a, input logic [15:0] d);
    hsel   <= 1'b1;
    haddr  <= {18'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= {16'h0, d};
    wait_rdy();
  endtask : xfer

  task rd(input logic [13:0] a, input logic [15:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 16'h0);
  endtask : rd

  // Random event bursts on all ports; the model tallies what should count
  task burst(input int n);
    logic [31:0] e;
    logic [10:0] o;
    logic [10:0] t;
    for (int i = 0; i < n; i++)
    begin
      for (int p = 0; p < 3; p++)
      begin
        e = $random(seed);
        o = $random(seed);
        t = $random(seed);
        ev[p]  <= e;
        rxo[p] <= o;
        txo[p] <= t;
        for (int k = 0; k < 32; k++)
          if (e[k] && k != 1 && k != 21)
            cnt[p*32+k] += (k == 0) ? o : (k == 20) ? t : 11'h1;
      end
      e = $random(seed);
      drop_event <= e[3:0];
      for (int j = 0; j < 4; j++)
        if (e[j]) drp[j]++;
      @(posedge hclk);
    end
    for (int p = 0; p < 3; p++)
      ev[p] <= 32'h0;
    drop_event <= 4'h0;
  endtask : burst

  // Read command then both halves; per-port words clear, drop words stay
  task cnt_read(input int a);
    logic [15:0] hi;
    logic [15:0] lo;
    hi = 16'h0;
    lo = 16'h0;
    if (a < 96)
    begin
      if (a % 32 != 1 && a % 32 != 21) hi = {2'b01, cnt[a][29:16]};
      lo = cnt[a][15:0];
      cnt[a] = 30'h0;
    end
    else if (a == 256 || a == 257 || a == 259 || a == 260)
      lo = drp[(a < 258) ? a - 256 : a - 257];
    xfer(1'b1, `SSC_ADDR_CTRL, 16'h1c00 | a[9:0]);
    rd(`SSC_ADDR_DATA_HI, hi);
    rd(`SSC_ADDR_DATA_LO, lo);
  endtask : cnt_read

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    seed = 32'ha35a;
    hresetn = 1'b0;
    {hsel, hwrite, bad_count, comparisons} = '0;
    {haddr, hwdata, htrans, drop_event} = '0;
    hsize = 3'b010;
    for (int p = 0; p < 3; p++)
      {ev[p], rxo[p], txo[p]} = '0;
    foreach (cnt[i]) cnt[i] = 30'h0;
    foreach (drp[i]) drp[i] = 16'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`SSC_ADDR_CTRL, 16'h0);
    rd(`SSC_ADDR_DATA_HI, 16'h0);
    rd(`SSC_ADDR_DATA_LO, 16'h0);
    $display("test reset values done");
    // Second round shows the first round's reads cleared every counter
    for (int r = 0; r < 2; r++)
    begin
      burst(40);
      for (int a = 0; a < 96; a++)
        cnt_read(a);
    end
    $display("test per-port counters done");
    burst(20);
    for (int r = 0; r < 2; r++)
      for (int a = 256; a < 261; a++)
        cnt_read(a);
    cnt_read(96);
    cnt_read(260);
    $display("test drop counters done");
    // Refused accesses leave the snapshot alone
    xfer(1'b1, `SSC_ADDR_CTRL, 16'h0c05);
    rd(`SSC_ADDR_CTRL, 16'h0c05);
    rd(`SSC_ADDR_DATA_LO, drp[3]);
    xfer(1'b1, `SSC_ADDR_DATA_LO, 16'hffff);
    rd(`SSC_ADDR_DATA_LO, drp[3]);
    rd(14'h0ffc, 16'h0);
    @(posedge hclk);
    $display("test refused accesses done");
    report_and_stop();
  end
endmodule : tb_top
